// ==== inc/sar_adc_defs.svh ====
// Offsets, field positions, reset values and timing counts of the converter
`ifndef SAR_ADC_DEFS_SVH
`define SAR_ADC_DEFS_SVH
`define OFS_STATUS_CONTROL 4'h0
`define OFS_RESULT_HIGH    4'h4
`define OFS_RESULT_LOW     4'h8
`define OFS_CLOCK_CONFIG   4'hC
`define OFS_STATUS_INPUTS  4'h0
`define SC_DONE_BIT        7
`define SC_IRQ_EN_BIT      6
`define SC_CONT_BIT        5
`define CH_OFF_CODE        5'h1f
`define CC_LOW_POWER_BIT   7
`define CC_DIV_HI          6
`define CC_DIV_LO          5
`define CC_INPUT_CLK_BIT   4
`define CC_MODE_HI         3
`define CC_MODE_LO         2
`define CC_LONG_SAMPLE_BIT 1
`define CC_ASYNC_EN_BIT    0
`define SC_RESET_VALUE     8'h1f
`define CC_RESET_VALUE     8'h00
`define MODE_8BIT          2'b00
`define MODE_10BIT         2'b01
`define SAMPLE_SHORT_HALF  6'd7
`define SAMPLE_LONG_HALF   6'd47
`define STEPS_8BIT         4'd8
`define STEPS_10BIT        4'd10
`define ASYNC_DIV_HP       8'd13
`define ASYNC_DIV_LP       8'd25
`endif

// ==== inc/sar_adc_pkg.sv ====
// Types shared by the converter control logic
package sar_adc_pkg;
  typedef enum logic [1:0] {st_idle, st_sample, st_convert} conv_state_e;
endpackage

// ==== rtl/sar_adc_control_registers.sv ====
// Control, clocking and result registers of a 10-bit successive approximation converter
`timescale 1ns/100ps
`include "sar_adc_defs.svh"
// Overview of operation
// RL1: Any control write aborts a conversion and starts one unless channel is all ones.
// RL2: Done flag sets at conversion end, clears on control write or low result read.
// RL3: With interrupt enabled, request rises at conversion end, clears on read or write.
// RL4: Continuous bit with live channel converts back to back, updating results each time.
// RL5: Continuous mode stops on reset, stop without async clock, clock write, control write.
// RL6: After a stop abort, conversions resume only after a new control write.
// RL7: Single mode: each control write with live channel gives exactly one conversion.
// RL8: Five-bit channel field; all ones turns converter off and isolates the pad.
// RL9: Converter drops to low power whenever a conversion completes outside continuous mode.
// RL10: Unused or reserved channels still convert; the result is undefined.
// RL11: High result holds upper bits, updates at completion, unused bits read zero.
// RL12: In 10-bit mode, high read blocks transfers until low read; late results lost.
// RL13: In 8-bit mode high and low results have no read interlock.
// RL14: Two-bit divider codes 0..3 divide the input clock by 1, 2, 4, 8.
// RL15: Without async clock, select bit picks bus clock when set, alternate when clear.
// RL16: Mode 00 is 8-bit, 01 is 10-bit, 10 and 11 reserved; reset gives 8-bit.
// RL17: Result rounds to the selected width, keeping error within half an LSB.
// RL18: Long sample bit gives 23.5 conversion clocks of sampling, else 3.5.
// RL19: Async enable clocks conversions by async source, only while active, also in stop.
// RL20: Async source runs 1 to 2 MHz, or 0.5 to 1 MHz in low power.
// RL21: Low power bit selects the reduced power setting, clear selects high speed.
// RL22: Software keeps bus clock fast enough for precise continuous sample timing.
// RL23: Done flag sets at every conversion end regardless of interrupt enable.
// RL24: Stop without async clock aborts the conversion; results keep the last value.
// RL25: After sampling, one approximation step per conversion clock per result bit; the code takes one extra step for the rounding bit.
module sar_adc_control_registers
  import sar_adc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        stop_mode,
  input  wire logic        alt_clock_tick,
  input  wire logic        comparator_high,
  output logic             done_irq,
  output logic [4:0]       channel_select,
  output logic             pad_isolate,
  output logic             converter_powered,
  output logic             low_power_config,
  output logic             sample_active,
  output logic [9:0]       dac_trial
);

  // ****************************************************************
  // Synchronisers
  // ****************************************************************
  logic [1:0] stop_sync_r;
  logic [1:0] alt_sync_r;
  logic [1:0] cmp_sync_r;
  logic       alt_prev_r;
  logic [1:0] stop_sync_nxt;
  logic [1:0] alt_sync_nxt;
  logic [1:0] cmp_sync_nxt;
  logic       alt_prev_nxt;
  logic       stop_s;
  logic       alt_tick;
  logic       cmp_s;

  always_comb begin
    stop_sync_nxt = {stop_sync_r[0], stop_mode};
    alt_sync_nxt  = {alt_sync_r[0], alt_clock_tick};
    cmp_sync_nxt  = {cmp_sync_r[0], comparator_high};
    alt_prev_nxt  = alt_sync_r[1];
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      stop_sync_r <= 2'b00;
      alt_sync_r  <= 2'b00;
      cmp_sync_r  <= 2'b00;
      alt_prev_r  <= 1'b0;
    end else begin
      stop_sync_r <= stop_sync_nxt;
      alt_sync_r  <= alt_sync_nxt;
      cmp_sync_r  <= cmp_sync_nxt;
      alt_prev_r  <= alt_prev_nxt;
    end
  end

  assign stop_s   = stop_sync_r[1];
  assign alt_tick = alt_sync_r[1] & ~alt_prev_r;
  assign cmp_s    = cmp_sync_r[1];

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic wr_sc;
  logic wr_cc;
  logic rd_rh;
  logic rd_rl;
  logic rd_first;
  logic rd_ack_r;
  logic rd_ack_nxt;

  // Reads wait one cycle so that read data comes from a flip-flop
  assign rd_first        = avs_read && !rd_ack_r;
  assign rd_ack_nxt      = rd_first;
  assign avs_waitrequest = rd_first;
  assign wr_sc = avs_write && (avs_address == `OFS_STATUS_CONTROL);
  assign wr_cc = avs_write && (avs_address == `OFS_CLOCK_CONFIG);
  // Read side effects act once, in the first cycle of a read
  assign rd_rh = rd_first && (avs_address == `OFS_RESULT_HIGH);
  assign rd_rl = rd_first && (avs_address == `OFS_RESULT_LOW);

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rd_ack_r <= 1'b0;
    end else begin
      rd_ack_r <= rd_ack_nxt;
    end
  end

  // ****************************************************************
  // Registers and conversion engine
  // ****************************************************************
  logic [7:0]  sc_r, sc_nxt;
  logic [7:0]  cc_r, cc_nxt;
  logic        done_r, done_nxt;
  logic        irq_r, irq_nxt;
  logic        lock_r, lock_nxt;
  logic [9:0]  res_r, res_nxt;
  conv_state_e st_r, st_nxt;
  logic [5:0]  half_r, half_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [10:0] sar_r, sar_nxt;
  logic [10:0] sar_shift;
  logic [7:0]  adiv_r, adiv_nxt;
  logic [7:0]  async_cnt_r, async_cnt_nxt;
  logic        tick;
  logic        tick_in;
  logic        mode10;
  logic        ch_off;
  logic [3:0]  nbits;
  logic [9:0]  rounded;

  function automatic logic [7:0] div_ratio(input logic [1:0] code);
    div_ratio = 8'h01 << code;  // see RL14
  endfunction

  // ****************************************************************
  // Rounding
  // ****************************************************************
  // Round the raw approximation, last trial bit included, to the width
  function automatic logic [9:0] round_result(input logic [10:0] raw,
                                              input logic        ten_bit);
    if (ten_bit) begin
      round_result = (raw[10:1] == 10'h3ff) ? 10'h3ff
                     : raw[10:1] + {9'h000, raw[0]};  // see RL17
    end else begin
      // Eight-bit mode shifts in only nine trial bits
      round_result = (raw[8:1] == 8'hff) ? 10'h0ff
                     : {2'b00, raw[8:1] + {7'h00, raw[0]}};  // see RL17
    end
  endfunction

  assign mode10 = (cc_r[`CC_MODE_HI:`CC_MODE_LO] == `MODE_10BIT); // see RL16
  assign ch_off = (sc_r[4:0] == `CH_OFF_CODE);
  assign nbits  = mode10 ? `STEPS_10BIT : `STEPS_8BIT;
  assign sar_shift = {sar_r[9:0], cmp_s};
  assign rounded   = round_result(sar_shift, mode10);

  // ****************************************************************
  // Input clock and divider
  // ****************************************************************

  // Input clock choice, async source runs only while converting
  always_comb begin
    async_cnt_nxt = 8'h00;
    tick_in       = 1'b0;
    if (cc_r[`CC_ASYNC_EN_BIT]) begin  // see RL19
      if (st_r != st_idle) begin
        async_cnt_nxt = async_cnt_r + 8'h01;
        // see RL20 see RL21
        if (async_cnt_r >= (cc_r[`CC_LOW_POWER_BIT] ? `ASYNC_DIV_LP
                                                    : `ASYNC_DIV_HP)) begin
          async_cnt_nxt = 8'h00;
          tick_in       = 1'b1;
        end
      end
    end else if (cc_r[`CC_INPUT_CLK_BIT]) begin  // see RL15
      tick_in = 1'b1;
    end else begin
      tick_in = alt_tick;
    end
  end

  // Divider by 1, 2, 4 or 8
  always_comb begin
    adiv_nxt = adiv_r;
    tick     = 1'b0;
    if (tick_in) begin
      if (adiv_r + 8'h01 >= div_ratio(cc_r[`CC_DIV_HI:`CC_DIV_LO])) begin
        adiv_nxt = 8'h00;
        tick     = 1'b1;  // see RL14
      end else begin
        adiv_nxt = adiv_r + 8'h01;
      end
    end
    if (st_r == st_idle) begin
      adiv_nxt = 8'h00;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      adiv_r      <= 8'h00;
      async_cnt_r <= 8'h00;
    end else begin
      adiv_r      <= adiv_nxt;
      async_cnt_r <= async_cnt_nxt;
    end
  end

  // ****************************************************************
  // Register and state update
  // ****************************************************************
  always_comb begin
    sc_nxt   = sc_r;
    cc_nxt   = cc_r;
    done_nxt = done_r;
    irq_nxt  = irq_r;
    lock_nxt = lock_r;
    res_nxt  = res_r;
    st_nxt   = st_r;
    half_nxt = half_r;
    bit_nxt  = bit_r;
    sar_nxt  = sar_r;
    // Clears first so that a completion in the same cycle wins
    if (rd_rl) begin
      done_nxt = 1'b0;  // see RL2
      irq_nxt  = 1'b0;  // see RL3
      lock_nxt = 1'b0;
    end
    if (rd_rh) begin
      irq_nxt = 1'b0;  // see RL3
      if (mode10) begin
        lock_nxt = 1'b1;  // see RL12
      end
    end
    case (st_r)
      st_idle: begin
      end
      st_sample: begin
        if (tick) begin
          if (half_r <= 6'd2) begin
            st_nxt  = st_convert;
            bit_nxt = 4'h0;
            sar_nxt = 11'h000;
          end else begin
            half_nxt = half_r - 6'd2;
          end
        end
      end
      st_convert: begin
        if (tick) begin
          // see RL25 see RL10
          sar_nxt = sar_shift;
          bit_nxt = bit_r + 4'h1;
          if (bit_r + 4'h1 == nbits + 4'h1) begin
            done_nxt = 1'b1;  // see RL2 see RL23
            if (sc_r[`SC_IRQ_EN_BIT]) begin
              irq_nxt = 1'b1;  // see RL3
            end
            if (!(lock_r && mode10)) begin  // see RL12 see RL13
              res_nxt = rounded;  // see RL11
            end
            if (sc_r[`SC_CONT_BIT]) begin
              st_nxt   = st_sample;  // see RL4
              half_nxt = cc_r[`CC_LONG_SAMPLE_BIT] ? `SAMPLE_LONG_HALF
                                                   : `SAMPLE_SHORT_HALF;
            end else begin
              st_nxt = st_idle;  // see RL7 see RL9
            end
          end
        end
      end
      default: st_nxt = st_idle;
    endcase
    // Stop without async clock aborts and ends continuous mode
    if (stop_s && !cc_r[`CC_ASYNC_EN_BIT]) begin
      st_nxt = st_idle;  // see RL5 see RL6 see RL24
    end
    if (wr_cc) begin
      cc_nxt = avs_writedata[7:0];
      st_nxt = st_idle;  // see RL5
      if (avs_writedata[`CC_MODE_HI:`CC_MODE_LO] != `MODE_10BIT) begin
        lock_nxt = 1'b0;
      end
    end
    if (wr_sc) begin
      sc_nxt   = {1'b0, avs_writedata[6:0]};
      done_nxt = 1'b0;  // see RL2
      irq_nxt  = 1'b0;  // see RL3
      if (avs_writedata[4:0] == `CH_OFF_CODE) begin
        st_nxt = st_idle;  // see RL8
      end else begin
        st_nxt   = st_sample;  // see RL1 see RL5 see RL7
        half_nxt = cc_r[`CC_LONG_SAMPLE_BIT] ? `SAMPLE_LONG_HALF
                                             : `SAMPLE_SHORT_HALF;  // see RL18
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      sc_r        <= `SC_RESET_VALUE;
      cc_r        <= `CC_RESET_VALUE;  // see RL16
      done_r      <= 1'b0;
      irq_r       <= 1'b0;
      lock_r      <= 1'b0;
      res_r       <= 10'h000;
      st_r        <= st_idle;  // see RL5
      half_r      <= 6'd0;
      bit_r       <= 4'h0;
      sar_r       <= 11'h000;
    end else begin
      sc_r        <= sc_nxt;
      cc_r        <= cc_nxt;
      done_r      <= done_nxt;
      irq_r       <= irq_nxt;
      lock_r      <= lock_nxt;
      res_r       <= res_nxt;
      st_r        <= st_nxt;
      half_r      <= half_nxt;
      bit_r       <= bit_nxt;
      sar_r       <= sar_nxt;
    end
  end

  // ****************************************************************
  // Read data and pins
  // ****************************************************************
  logic [31:0] rdata_r, rdata_nxt;

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (rd_first) begin
      case (avs_address)
        `OFS_STATUS_CONTROL: rdata_nxt = {24'h00_0000, done_r, sc_r[6:0]};
        `OFS_RESULT_HIGH: rdata_nxt = {30'h0000_0000, res_r[9:8]};  // see RL11
        `OFS_RESULT_LOW: rdata_nxt = {24'h00_0000, res_r[7:0]};
        `OFS_CLOCK_CONFIG: rdata_nxt = {24'h00_0000, cc_r};
        default: rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Read data stands from the flip-flop in the cycle the read is accepted
  assign avs_readdata      = rdata_r;
  assign done_irq          = irq_r;
  assign channel_select    = sc_r[4:0];  // see RL8
  assign pad_isolate       = ch_off;  // see RL8
  assign converter_powered = (st_r != st_idle);  // see RL9
  assign low_power_config  = cc_r[`CC_LOW_POWER_BIT];  // see RL21
  assign sample_active     = (st_r == st_sample);
  assign dac_trial         = sar_r[9:0];

endmodule // sar_adc_control_registers

// ==== test/sar_adc_control_registers_asserts.sv ====
// Concurrent checks on the converter control ports
`timescale 1ns/100ps
module sar_adc_control_registers_asserts (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        done_irq,
  input wire logic [4:0]  channel_select,
  input wire logic        pad_isolate,
  input wire logic        converter_powered,
  input wire logic        low_power_config,
  input wire logic        sample_active
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence sc_wr; avs_write && avs_address == 4'h0; endsequence
  sequence live_wr; sc_wr ##0 avs_writedata[4:0] != 5'h1f; endsequence
  sequence off_wr; sc_wr ##0 avs_writedata[4:0] == 5'h1f; endsequence
  start_conv_a:
    assert property (live_wr |=> converter_powered && sample_active)
    else $error("no start after control write");
  off_code_a:
    assert property (off_wr |=> pad_isolate && !converter_powered)
    else $error("off code left converter on");
  chan_field_a:
    assert property (sc_wr |=> channel_select == $past(avs_writedata[4:0]))
    else $error("channel field not taken");
  irq_wr_clr_a:
    assert property (sc_wr |=> !done_irq)
    else $error("irq kept after control write");
  irq_rd_clr_a:
    assert property (avs_read && avs_address == 4'h8 && !converter_powered
      |=> !done_irq)
    else $error("irq kept after result read");
  irq_cause_a:
    assert property ($rose(done_irq) |-> $past(converter_powered))
    else $error("irq without conversion");
  low_pow_a:
    assert property (avs_write && avs_address == 4'hC
      |=> low_power_config == $past(avs_writedata[7]))
    else $error("low power bit not taken");
  high_zero_a:
    assert property (avs_read && avs_address == 4'h4 && !avs_waitrequest
      |-> avs_readdata[31:2] == 30'h0)
    else $error("unused high bits set");
  rd_wait_a:
    assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
    else $error("read wait longer than one cycle");
endmodule // sar_adc_control_registers_asserts
bind sar_adc_control_registers sar_adc_control_registers_asserts u_chk (
  .mclk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_readdata, .avs_waitrequest, .done_irq, .channel_select, .pad_isolate,
  .converter_powered, .low_power_config, .sample_active);

// ==== test/sar_adc_control_registers_test.sv ====
// Self-checking bench of the converter control registers
`timescale 1ns/100ps
module sar_adc_control_registers_test;
  logic        mclk, nrst, avs_read, avs_write, stop_mode, alt_clock_tick;
  logic        avs_waitrequest, comparator_high, done_irq, pad_isolate;
  logic        converter_powered, low_power_config, sample_active;
  logic [3:0]  avs_address;
  logic [4:0]  channel_select;
  logic [9:0]  dac_trial;
  logic [31:0] avs_writedata, avs_readdata, rnd, d;
  int          n_fail, checks, cyc, t;
  int          tm[8];
  bit          rnd_cmp;
  sar_adc_control_registers u_sar_adc_control_registers (.mclk, .nrst,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .stop_mode, .alt_clock_tick, .comparator_high,
    .done_irq, .channel_select, .pad_isolate, .converter_powered,
    .low_power_config, .sample_active, .dac_trial);
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [31:0] sts(input logic irq);
    return {24'h0, 1'b1, irq, 6'h03};
  endfunction
  task automatic end_of_test;
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    avs_address <= a;
    avs_writedata <= {24'h0, v};
    avs_write <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [3:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    d = avs_readdata;
    avs_read <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic poll_done;
    t = 0;
    do begin
      rd(4'h0);
      t++;
    end while (d[7] !== 1'b1 && t < 3000);
  endtask
  task automatic conv(input logic [7:0] v);
    wr(4'h0, v);
    poll_done();
  endtask
  // ****************************************
  // Clock, stimulus and timeout
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    rnd <= xs(rnd);
    alt_clock_tick <= (cyc % 6) < 3;
    if (rnd_cmp) comparator_high <= rnd[0];
    if (cyc == 60000) begin
      n_fail++;
      end_of_test();
    end
  end
  initial begin
    {nrst, avs_read, avs_write, stop_mode, alt_clock_tick} = 5'h0;
    {avs_address, avs_writedata, comparator_high} = 37'h0;
    rnd = 32'h8b3f_68cb;
    rnd_cmp = 1;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    rd(4'h0); cmp(d, 32'h1f);
    rd(4'hC); cmp(d, 32'h0);
    rd(4'h2); cmp(d, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(4'hC, {1'b0, i[1:0], 1'b1, 2'b01, i[2], 1'b0});
      conv({1'b0, i[0], 6'h03});
      tm[i] = t;
      cmp(d, sts(i[0]));
      cmp(32'(done_irq), 32'(i[0]));
      cmp(32'(converter_powered), 32'h0);
      rd(4'h4);
      rd(4'h8); rd(4'h0); cmp(d[7], 32'h0);
      cmp(32'(done_irq), 32'h0);
    end
    for (int i = 1; i < 8; i++)
      if (i != 4) cmp(32'(tm[i] > tm[i-1]), 32'h1);
    cmp(32'(tm[4] > tm[0]), 32'h1);
    wr(4'hC, 8'h00); conv(8'h03); cmp(d[7], 32'h1);
    rnd_cmp = 0;
    for (int m = 0; m < 2; m++) begin
      wr(4'hC, {4'h1, 1'b0, m[0], 2'b00});
      comparator_high <= 1'b0;
      conv(8'h03); rd(4'h4);
      cmp(32'(dac_trial), 32'h0);
      comparator_high <= 1'b1;
      conv(8'h03);
      cmp(32'(dac_trial != 0), 32'h1);
      rd(4'h8); cmp(32'(d == 0), 32'(m));
      cmp(d, m[0] ? 32'h0 : 32'hff);
    end
    rnd_cmp = 1;
    conv(8'h23); rd(4'h8); poll_done(); cmp(d[7], 32'h1);
    wr(4'hC, 8'h10); repeat (600) @(posedge mclk);
    cmp(32'(converter_powered), 32'h0);
    wr(4'h0, 8'h23); repeat (20) @(posedge mclk);
    stop_mode <= 1'b1; repeat (6) @(posedge mclk);
    cmp(32'(converter_powered), 32'h0);
    stop_mode <= 1'b0; repeat (400) @(posedge mclk);
    cmp(32'(converter_powered), 32'h0);
    wr(4'hC, 8'h81); cmp(32'(low_power_config), 32'h1);
    stop_mode <= 1'b1;
    conv(8'h43); cmp(d, sts(1'b1));
    stop_mode <= 1'b0;
    wr(4'h0, 8'h3f); repeat (600) @(posedge mclk);
    cmp(32'(pad_isolate && !converter_powered), 32'h1);
    wr(4'h0, 8'h23); repeat (30) @(posedge mclk);
    cmp(32'(converter_powered), 32'h1);
    nrst <= 1'b0; repeat (2) @(posedge mclk);
    nrst <= 1'b1; @(posedge mclk);
    cmp(32'(converter_powered), 32'h0);
    rd(4'h0); cmp(d, 32'h1f);
    rd(4'hC); cmp(d, 32'h0);
    end_of_test();
  end
endmodule // sar_adc_control_registers_test
